// ---- rtl/dsaa_pkg.sv ----
// DMA Setup auto-activate: shared constants and types.
// Assumes a 32-bit dword word path between the transport ends.
package dsaa_pkg;
	localparam logic [7:0] FIS_TYPE_DMA_SETUP = 8'h41;
	localparam logic [7:0] FIS_TYPE_DMA_ACT   = 8'h39;
	localparam logic [7:0] FIS_TYPE_DATA      = 8'h46;
	localparam int         SETUP_DWORDS       = 7;
	localparam logic [2:0] SETUP_LAST_IDX     = 3'h6;
	// Field positions in dword 0
	localparam int         TYPE_LSB           = 0;
	localparam int         DIR_BIT            = 13;
	localparam int         INTR_BIT           = 14;
	localparam int         AUTO_ACT_BIT       = 15;
	// Dword indices of setup fields
	localparam logic [2:0] IDX_HDR            = 3'h0;
	localparam logic [2:0] IDX_BUF_LO         = 3'h1;
	localparam logic [2:0] IDX_BUF_HI         = 3'h2;
	localparam logic [2:0] IDX_OFFSET         = 3'h4;
	localparam logic [2:0] IDX_COUNT          = 3'h5;
	localparam logic [31:0] ZERO_WORD         = 32'h0000_0000;

	typedef struct packed {
		logic [63:0] buf_id;
		logic [31:0] buf_offset;
		logic [31:0] xfer_count;
		logic        dir_d2h;
		logic        auto_act;
	} dsaa_ctx_s;
endpackage

// ---- rtl/dsaa_link_if.sv ----
// Word link between host transport end and device transport end.
// Assumes both ends share i_clk; no clocking block.
`timescale 1ns/1ns
interface dsaa_link_if;
	// Device to host words
	logic [31:0] d2h_data;
	logic        d2h_valid;
	logic        d2h_sof;
	logic        d2h_eof;
	// Host to device words
	logic [31:0] h2d_data;
	logic        h2d_valid;
	logic        h2d_sof;
	logic        h2d_eof;
	// Link illegal-transition notice to host
	logic        illegal_trans;

	modport host
	(
		input  d2h_data, d2h_valid, d2h_sof, d2h_eof, illegal_trans,
		output h2d_data, h2d_valid, h2d_sof, h2d_eof
	);
	modport dev
	(
		output d2h_data, d2h_valid, d2h_sof, d2h_eof, illegal_trans,
		input  h2d_data, h2d_valid, h2d_sof, h2d_eof
	);
endinterface

// ---- rtl/dsaa_host_xport.sv ----
// Host transport end: receives DMA Setup, loads DMA context,
// and on auto-activate starts the first outbound Data frame.
// Assumes the link delivers whole frames, one word per valid cycle.
`timescale 1ns/1ns
module dsaa_host_xport
(
	// Clock and reset
	input  wire logic          i_clk,
	input  wire logic          i_rst,
	// Link side
	dsaa_link_if.host          link,
	// User control
	input  wire logic          i_auto_en,
	input  wire logic [31:0]   i_tx_word,
	// User status
	output logic               o_tx_take,
	output logic               o_ctx_valid,
	output dsaa_pkg::dsaa_ctx_s o_ctx,
	output logic               o_setup_err,
	output logic               o_xfer_done
);
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RX_SETUP,
		ST_SETUP_DONE,
		ST_WAIT_END,
		ST_OUT_DATA
	} dsaa_hst_e;

	typedef struct packed {
		dsaa_hst_e           st;
		logic [2:0]          idx;
		logic                err;
		logic [31:0]         left;
		logic                first;
		dsaa_pkg::dsaa_ctx_s ctx;
		logic                ctx_valid;
		logic                setup_err;
		logic                done;
		logic [31:0]         tx_data;
		logic                tx_valid;
		logic                tx_sof;
		logic                tx_eof;
	} dsaa_hst_s;

	dsaa_hst_s cur_ff;
	dsaa_hst_s nxt_cur;

	// Activate frame header on the link
	function automatic logic act_hdr(input logic v, input logic s,
		input logic [31:0] w);
		return v && s && w[7:0] == dsaa_pkg::FIS_TYPE_DMA_ACT;
	endfunction

	// --------------------------------------------------------------
	// Next state
	// --------------------------------------------------------------
	always_comb
	begin
		nxt_cur          = cur_ff;
		nxt_cur.done     = 1'b0;
		nxt_cur.tx_valid = 1'b0;
		nxt_cur.tx_sof   = 1'b0;
		nxt_cur.tx_eof   = 1'b0;
		o_tx_take        = 1'b0;
		unique case (cur_ff.st)
			ST_IDLE:
			begin
				if (link.d2h_valid && link.d2h_sof && link.d2h_data[7:0]
					== dsaa_pkg::FIS_TYPE_DMA_SETUP)
				begin
					nxt_cur.st        = ST_RX_SETUP;
					nxt_cur.idx       = 3'h1;
					nxt_cur.err       = link.d2h_eof;
					nxt_cur.ctx_valid = 1'b0;
					nxt_cur.ctx.dir_d2h =
						link.d2h_data[dsaa_pkg::DIR_BIT];
					nxt_cur.ctx.auto_act = i_auto_en &&
						link.d2h_data[dsaa_pkg::AUTO_ACT_BIT];
					if (link.d2h_eof)
						nxt_cur.st = ST_SETUP_DONE;
				end
				else if (act_hdr(link.d2h_valid, link.d2h_sof,
					link.d2h_data) && cur_ff.ctx_valid && !cur_ff.ctx.dir_d2h)
				begin
					nxt_cur.st    = ST_OUT_DATA;
					nxt_cur.first = 1'b1;
					nxt_cur.left  = cur_ff.ctx.xfer_count;
					if (!link.d2h_eof)
						nxt_cur.st = ST_WAIT_END;
				end
			end
			ST_WAIT_END:
			begin
				if (link.d2h_valid && link.d2h_eof)
					nxt_cur.st = ST_OUT_DATA;
			end
			ST_RX_SETUP:
			begin
				if (link.d2h_valid)
				begin
					// Load context fields by word index
					unique case (cur_ff.idx)
						dsaa_pkg::IDX_BUF_LO:
							nxt_cur.ctx.buf_id[31:0] = link.d2h_data;
						dsaa_pkg::IDX_BUF_HI:
							nxt_cur.ctx.buf_id[63:32] = link.d2h_data;
						dsaa_pkg::IDX_OFFSET:
							nxt_cur.ctx.buf_offset = link.d2h_data;
						dsaa_pkg::IDX_COUNT:
							nxt_cur.ctx.xfer_count = link.d2h_data;
						default:
							nxt_cur.ctx = cur_ff.ctx;
					endcase
					nxt_cur.idx = cur_ff.idx + 3'h1;
					if (link.d2h_eof)
					begin
						nxt_cur.st  = ST_SETUP_DONE;
						nxt_cur.err = cur_ff.err ||
							cur_ff.idx != dsaa_pkg::SETUP_LAST_IDX;
					end
					else if (cur_ff.idx == dsaa_pkg::SETUP_LAST_IDX)
						nxt_cur.err = 1'b1;
				end
			end
			ST_SETUP_DONE:
			begin
				// Context complete; choose next state
				nxt_cur.ctx_valid = !cur_ff.err;
				nxt_cur.setup_err = cur_ff.err;
				nxt_cur.first     = 1'b1;
				nxt_cur.left      = cur_ff.ctx.xfer_count;
				if (cur_ff.err)
					nxt_cur.st = ST_IDLE;
				else if (cur_ff.ctx.auto_act && !cur_ff.ctx.dir_d2h)
					nxt_cur.st = ST_OUT_DATA;
				else if (act_hdr(link.d2h_valid, link.d2h_sof,
					link.d2h_data) && !cur_ff.ctx.dir_d2h)
				begin
					// Activate right behind the setup frame
					nxt_cur.st = ST_OUT_DATA;
					if (!link.d2h_eof)
						nxt_cur.st = ST_WAIT_END;
				end
				else
					nxt_cur.st = ST_IDLE;
			end
			ST_OUT_DATA:
			begin
				o_tx_take        = 1'b1;
				nxt_cur.tx_valid = 1'b1;
				nxt_cur.tx_sof   = cur_ff.first;
				nxt_cur.tx_data  = cur_ff.first ?
					{24'h00_0000, dsaa_pkg::FIS_TYPE_DATA} : i_tx_word;
				o_tx_take        = !cur_ff.first;
				nxt_cur.first    = 1'b0;
				if (!cur_ff.first)
					nxt_cur.left = cur_ff.left - 32'h0000_0004;
				if (!cur_ff.first && cur_ff.left <= 32'h0000_0004)
				begin
					nxt_cur.tx_eof = 1'b1;
					nxt_cur.done   = 1'b1;
					nxt_cur.st     = ST_IDLE;
				end
			end
			default:
				nxt_cur.st = ST_IDLE;
		endcase
		if (link.illegal_trans && cur_ff.st != ST_IDLE)
		begin
			nxt_cur.st        = ST_IDLE;
			nxt_cur.setup_err = cur_ff.st == ST_RX_SETUP ||
				cur_ff.st == ST_SETUP_DONE;
			nxt_cur.tx_valid  = 1'b0;
		end
	end

	// --------------------------------------------------------------
	// State register
	// --------------------------------------------------------------
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			cur_ff <= '0;
		else
			cur_ff <= nxt_cur;
	end

	assign link.h2d_data  = cur_ff.tx_data;
	assign link.h2d_valid = cur_ff.tx_valid;
	assign link.h2d_sof   = cur_ff.tx_sof;
	assign link.h2d_eof   = cur_ff.tx_eof;
	assign o_ctx_valid    = cur_ff.ctx_valid;
	assign o_ctx          = cur_ff.ctx;
	assign o_setup_err    = cur_ff.setup_err;
	assign o_xfer_done    = cur_ff.done;
endmodule

// ---- rtl/dsaa_dev_xport.sv ----
// Device transport end: sends DMA Setup; for a host-to-device transfer it then sends
// DMA Activate only when auto-activate is not used, then accepts host data.
// Assumes the user starts a setup only when ready to take data.
`timescale 1ns/1ns
module dsaa_dev_xport
(
	// Clock and reset
	input  wire logic          i_clk,
	input  wire logic          i_rst,
	// Link side
	dsaa_link_if.dev           link,
	// User request
	input  wire logic          i_start,
	input  wire logic          i_dir_d2h,
	input  wire logic          i_auto_enabled,
	input  wire logic          i_want_auto,
	input  wire logic [63:0]   i_buf_id,
	input  wire logic [31:0]   i_buf_offset,
	input  wire logic [31:0]   i_xfer_count,
	input  wire logic          i_illegal_trans,
	// User status
	output logic               o_busy,
	output logic [31:0]        o_rx_word,
	output logic               o_rx_valid,
	output logic               o_rx_done
);
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_SEND_SETUP,
		ST_SEND_ACT,
		ST_RX_DATA
	} dsaa_dst_e;

	typedef struct packed {
		dsaa_dst_e   st;
		logic [2:0]  idx;
		logic        auto_act;
		logic        dir_d2h;
		logic [63:0] buf_id;
		logic [31:0] buf_offset;
		logic [31:0] xfer_count;
		logic [31:0] tx_data;
		logic        tx_valid;
		logic        tx_sof;
		logic        tx_eof;
		logic [31:0] rx_word;
		logic        rx_valid;
		logic        rx_done;
		logic        abort;
	} dsaa_dev_s;

	dsaa_dev_s cur_ff;
	dsaa_dev_s nxt_cur;

	// --------------------------------------------------------------
	// Next state
	// --------------------------------------------------------------
	always_comb
	begin
		nxt_cur          = cur_ff;
		nxt_cur.tx_valid = 1'b0;
		nxt_cur.tx_sof   = 1'b0;
		nxt_cur.tx_eof   = 1'b0;
		nxt_cur.rx_valid = 1'b0;
		nxt_cur.rx_done  = 1'b0;
		unique case (cur_ff.st)
			ST_IDLE:
			begin
				if (i_start)
				begin
					nxt_cur.st         = ST_SEND_SETUP;
					nxt_cur.idx        = 3'h0;
					nxt_cur.dir_d2h    = i_dir_d2h;
					nxt_cur.auto_act   = i_auto_enabled && i_want_auto &&
						!i_dir_d2h;
					nxt_cur.buf_id     = i_buf_id;
					nxt_cur.buf_offset = i_buf_offset;
					nxt_cur.xfer_count = i_xfer_count;
					nxt_cur.abort      = 1'b0;
				end
			end
			ST_SEND_SETUP:
			begin
				nxt_cur.tx_valid = 1'b1;
				nxt_cur.tx_sof   = cur_ff.idx == dsaa_pkg::IDX_HDR;
				nxt_cur.tx_eof   = cur_ff.idx == dsaa_pkg::SETUP_LAST_IDX;
				unique case (cur_ff.idx)
					dsaa_pkg::IDX_HDR:
					begin
						nxt_cur.tx_data = {16'h0000, 8'h00,
							dsaa_pkg::FIS_TYPE_DMA_SETUP};
						nxt_cur.tx_data[dsaa_pkg::DIR_BIT] = cur_ff.dir_d2h;
						nxt_cur.tx_data[dsaa_pkg::AUTO_ACT_BIT] =
							cur_ff.auto_act;
					end
					dsaa_pkg::IDX_BUF_LO: nxt_cur.tx_data = cur_ff.buf_id[31:0];
					dsaa_pkg::IDX_BUF_HI: nxt_cur.tx_data = cur_ff.buf_id[63:32];
					dsaa_pkg::IDX_OFFSET: nxt_cur.tx_data = cur_ff.buf_offset;
					dsaa_pkg::IDX_COUNT:  nxt_cur.tx_data = cur_ff.xfer_count;
					default:              nxt_cur.tx_data = dsaa_pkg::ZERO_WORD;
				endcase
				nxt_cur.idx = cur_ff.idx + 3'h1;
				if (cur_ff.idx == dsaa_pkg::SETUP_LAST_IDX)
				begin
					if (cur_ff.dir_d2h)
						nxt_cur.st = ST_IDLE;
					else if (cur_ff.auto_act)
						nxt_cur.st = ST_RX_DATA;
					else
						nxt_cur.st = ST_SEND_ACT;
				end
			end
			ST_SEND_ACT:
			begin
				nxt_cur.tx_valid = 1'b1;
				nxt_cur.tx_sof   = 1'b1;
				nxt_cur.tx_eof   = 1'b1;
				nxt_cur.tx_data  = {24'h00_0000, dsaa_pkg::FIS_TYPE_DMA_ACT};
				nxt_cur.st       = ST_RX_DATA;
			end
			ST_RX_DATA:
			begin
				if (link.h2d_valid && !link.h2d_sof)
				begin
					nxt_cur.rx_word  = link.h2d_data;
					nxt_cur.rx_valid = 1'b1;
				end
				if (link.h2d_valid && link.h2d_eof)
				begin
					nxt_cur.rx_done = 1'b1;
					nxt_cur.st      = ST_IDLE;
				end
			end
		endcase
		// Link error: host drops the exchange, so stop waiting for data
		if (i_illegal_trans && cur_ff.st != ST_IDLE)
			nxt_cur.abort = 1'b1;
		if (cur_ff.abort && cur_ff.st == ST_RX_DATA)
			nxt_cur.st = ST_IDLE;
	end

	// --------------------------------------------------------------
	// State register
	// --------------------------------------------------------------
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			cur_ff <= '0;
		else
			cur_ff <= nxt_cur;
	end

	assign link.d2h_data      = cur_ff.tx_data;
	assign link.d2h_valid     = cur_ff.tx_valid;
	assign link.d2h_sof       = cur_ff.tx_sof;
	assign link.d2h_eof       = cur_ff.tx_eof;
	assign link.illegal_trans = i_illegal_trans;
	assign o_busy             = cur_ff.st != ST_IDLE;
	assign o_rx_word          = cur_ff.rx_word;
	assign o_rx_valid         = cur_ff.rx_valid;
	assign o_rx_done          = cur_ff.rx_done;
endmodule

// ---- testbench/dsaa_link_chk.sv ----
// Checker on the word link between the two transport ends.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
module dsaa_link_chk
(
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	// Link signals
	input  wire logic [31:0] d2h_data,
	input  wire logic        d2h_valid,
	input  wire logic        d2h_sof,
	input  wire logic        d2h_eof,
	input  wire logic [31:0] h2d_data,
	input  wire logic        h2d_valid,
	input  wire logic        h2d_sof,
	input  wire logic        h2d_eof,
	input  wire logic        illegal_trans
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	// --------------------------------
	// Setup frame tracking
	// --------------------------------
	logic in_su_ff, auto_ff, dir_ff, ill_ff;
	wire  su_hdr = d2h_valid && d2h_sof
		&& d2h_data[7:0] == dsaa_pkg::FIS_TYPE_DMA_SETUP;
	wire  su_end = d2h_valid && d2h_eof && in_su_ff;
	wire  ok     = !(ill_ff || illegal_trans);
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			in_su_ff <= 1'b0;
			auto_ff  <= 1'b0;
			dir_ff   <= 1'b0;
			ill_ff   <= 1'b0;
		end
		else
		begin
			in_su_ff <= su_hdr || (in_su_ff && !su_end);
			if (su_hdr)
			begin
				auto_ff <= d2h_data[dsaa_pkg::AUTO_ACT_BIT];
				dir_ff  <= d2h_data[dsaa_pkg::DIR_BIT];
			end
			ill_ff <= !su_hdr && (ill_ff || (illegal_trans && in_su_ff));
		end
	end
	sequence s_act;
		d2h_valid && d2h_sof && d2h_eof
			&& d2h_data[7:0] == dsaa_pkg::FIS_TYPE_DMA_ACT;
	endsequence
	sequence s_hdr;
		h2d_valid && h2d_sof && h2d_data[7:0] == dsaa_pkg::FIS_TYPE_DATA;
	endsequence
	// --------------------------------
	// Assertions
	// --------------------------------
	chk_setup_words: assert property (su_hdr |=>
		(d2h_valid && !d2h_eof)[*5] ##1 (d2h_valid && d2h_eof))
		else $error("setup frame length wrong");
	chk_act_sent: assert property (
		su_end && !dir_ff && !auto_ff |=> s_act)
		else $error("activate missing after setup");
	chk_act_absent: assert property (
		su_end && auto_ff |=> (!(d2h_valid && d2h_sof))[*4])
		else $error("frame sent after auto setup");
	chk_auto_data: assert property (
		su_end && !dir_ff && auto_ff && ok |-> ##3 s_hdr)
		else $error("auto data header late");
	chk_act_then_data: assert property (
		su_end && !dir_ff && !auto_ff && ok ##1 s_act |-> ##2 s_hdr)
		else $error("data header late after activate");
	chk_d2h_quiet: assert property (
		su_end && dir_ff |=> (!h2d_valid)[*8])
		else $error("host sent data for d2h setup");
	chk_illegal_idle: assert property (
		in_su_ff && illegal_trans |=> (!h2d_valid)[*8])
		else $error("host sent data after illegal transition");
	chk_data_burst: assert property (s_hdr |=>
		h2d_valid && !h2d_sof)
		else $error("data word missing after header");
	chk_auto_dir: assert property (
		su_hdr && d2h_data[dsaa_pkg::AUTO_ACT_BIT]
			|-> !d2h_data[dsaa_pkg::DIR_BIT])
		else $error("auto flag on d2h setup");
endmodule

// ---- testbench/tb_dma_setup_auto_activate.sv ----
// Bench for host and device transport ends joined by the word link.
// Assumes a 250 MHz clock and a synchronous active-high reset.
`timescale 1ns/1ns
module tb_dma_setup_auto_activate;
	typedef struct packed {
		logic        dir;
		logic        want;
		logic        en;
		logic [31:0] cnt;
		logic        auto_x;
		logic [3:0]  words;
	} dsaa_row_s;
	logic                i_clk, i_rst, auto_en, start, dir, want, ill;
	logic                tx_take, ctx_valid, setup_err, xfer_done, busy;
	logic                rx_valid, rx_done;
	logic [63:0]         buf_id;
	logic [31:0]         off, cnt, tx_word, rx_word, rx_exp;
	dsaa_pkg::dsaa_ctx_s ctx;
	int                  err_count, cmp_count, rx_n, cyc, done_n, rd_n;
	dsaa_row_s           rows [5] = '{
		'{1'b0, 1'b1, 1'b1, 32'h0000_0008, 1'b1, 4'h2},
		'{1'b0, 1'b0, 1'b1, 32'h0000_000C, 1'b0, 4'h3},
		'{1'b0, 1'b1, 1'b0, 32'h0000_0004, 1'b0, 4'h1},
		'{1'b0, 1'b1, 1'b1, 32'h0000_0005, 1'b1, 4'h2},
		'{1'b1, 1'b1, 1'b1, 32'h0000_0010, 1'b0, 4'h0}};
	dsaa_link_if link ();
	dsaa_host_xport u_dsaa_host_xport (.i_clk(i_clk), .i_rst(i_rst),
		.link(link), .i_auto_en(auto_en), .i_tx_word(tx_word),
		.o_tx_take(tx_take), .o_ctx_valid(ctx_valid), .o_ctx(ctx),
		.o_setup_err(setup_err), .o_xfer_done(xfer_done));
	dsaa_dev_xport u_dsaa_dev_xport (.i_clk(i_clk), .i_rst(i_rst),
		.link(link), .i_start(start), .i_dir_d2h(dir),
		.i_auto_enabled(auto_en), .i_want_auto(want), .i_buf_id(buf_id),
		.i_buf_offset(off), .i_xfer_count(cnt), .i_illegal_trans(ill),
		.o_busy(busy), .o_rx_word(rx_word), .o_rx_valid(rx_valid),
		.o_rx_done(rx_done));
	dsaa_link_chk u_dsaa_link_chk (.i_clk(i_clk), .i_rst(i_rst),
		.d2h_data(link.d2h_data), .d2h_valid(link.d2h_valid),
		.d2h_sof(link.d2h_sof), .d2h_eof(link.d2h_eof),
		.h2d_data(link.h2d_data), .h2d_valid(link.h2d_valid),
		.h2d_sof(link.h2d_sof), .h2d_eof(link.h2d_eof),
		.illegal_trans(link.illegal_trans));
	// --------------------------------
	// Clock, monitor and timeout
	// --------------------------------
	initial
	begin
		i_clk = 1'b0;
		forever #2 i_clk = ~i_clk;
	end
	always @(posedge i_clk)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			err_count++;
			print_verdict();
		end
	end
	always @(posedge i_clk)
	begin
		if (rx_valid === 1'b1)
		begin
			chk("rx_word", rx_exp, rx_word);
			rx_exp++;
			rx_n++;
		end
		if (xfer_done === 1'b1)
			done_n++;
		if (rx_done === 1'b1)
			rd_n++;
		if (tx_take === 1'b1)
			#1 tx_word = tx_word + 32'h0000_0001;
	end
	// --------------------------------
	// Tasks
	// --------------------------------
	task automatic chk(input string nm, input logic [135:0] exp,
		input logic [135:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			err_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic drive(input dsaa_row_s r);
		{dir, want, auto_en, cnt} = {r.dir, r.want, r.en, r.cnt};
		buf_id = {32'hB0F0_0000, r.cnt};
		off = ~r.cnt;
		tx_word = 32'h1000_0000;
		rx_exp = 32'h1000_0000;
		rx_n = 0;
		done_n = 0;
		rd_n = 0;
		start = 1'b1;
		@(posedge i_clk);
		#1 start = 1'b0;
	endtask
	task automatic run(input dsaa_row_s r, input logic inj);
		int k;
		drive(r);
		repeat (3) @(posedge i_clk);
		#1 ill = inj;
		@(posedge i_clk);
		#1 ill = 1'b0;
		for (k = 0; k < 40 && ctx_valid !== 1'b1 && setup_err !== 1'b1; k++)
		begin
			@(posedge i_clk);
			#1;
		end
		repeat (12) @(posedge i_clk);
		#1;
		chk("ctx_valid", !inj, ctx_valid);
		chk("setup_err", inj, setup_err);
		chk("rx_words", inj ? 0 : r.words, rx_n);
		chk("xfer_done", (inj || r.dir) ? 0 : 1, done_n);
		chk("rx_done", (inj || r.dir) ? 0 : 1, rd_n);
		if (!inj)
		begin
			chk("auto_act", r.auto_x, ctx.auto_act);
			chk("ctx", {buf_id, off, cnt, dir, r.auto_x}, ctx);
		end
	endtask
	task print_verdict();
		$display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// --------------------------------
	// Main sequence
	// --------------------------------
	initial
	begin
		{i_rst, auto_en, start, dir, want, ill} = 6'b10_0000;
		{buf_id, off, cnt, tx_word, rx_exp} = 192'h0;
		{err_count, cmp_count, rx_n, cyc} = 128'h0;
		repeat (8) @(posedge i_clk);
		#1 i_rst = 1'b0;
		chk("idle", 5'h00, {link.h2d_valid, link.d2h_valid, busy,
			ctx_valid, setup_err});
		foreach (rows[i])
			run(rows[i], 1'b0);
		run(rows[0], 1'b1);
		run(rows[0], 1'b0);
		drive(rows[1]);
		repeat (5) @(posedge i_clk);
		#1 i_rst = 1'b1;
		repeat (2) @(posedge i_clk);
		#1 i_rst = 1'b0;
		chk("reset", 134'h0, {link.h2d_valid, link.d2h_valid, busy,
			ctx_valid, ctx});
		print_verdict();
	end
endmodule
